// ==== rtl/mpu_region_checker.sv ====
// mpu_region_checker: eight-region protection unit with background region
// assumes: register bus word accesses with byte strobes, checks registered
`timescale 1ns/100ps
`default_nettype none
module mpu_region_checker (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [31:0] i_reg_addr,
	input  wire logic [3:0]  i_reg_be,
	input  wire logic [31:0] i_reg_wdata,
	output logic [31:0]      o_reg_rdata,
	input  wire logic        i_mpu_enable,
	input  wire logic        i_acc_valid,
	input  wire logic [31:0] i_acc_addr,
	input  wire logic        i_acc_priv,
	input  wire logic        i_acc_write,
	input  wire logic        i_acc_fetch,
	output logic             o_fault,
	output logic             o_acc_ok,
	output logic [1:0]       o_mem_type,
	output logic             o_share,
	output logic [1:0]       o_inner,
	output logic [1:0]       o_outer
);
	typedef struct packed {
		logic [2:0]  sel;
		logic [mpu_pkg::NUM_REGIONS-1:0][26:0] base;
		logic [mpu_pkg::NUM_REGIONS-1:0][31:0] attr;
		logic [31:0] rdata;
		logic        fault;
		logic        ok;
		logic [1:0]  mtype;
		logic        share;
		logic [1:0]  inner;
		logic [1:0]  outer;
	} state_t;
	state_t st_r;
	state_t st_nxt;
	logic [mpu_pkg::NUM_REGIONS-1:0] hit;
	logic [2:0]  win;
	logic        any_hit;
	logic [31:0] wattr;
	mpu_pkg::mem_type_t dtype;
	logic        dshare;
	logic [1:0]  dinner;
	logic [1:0]  douter;
	logic        dallow;
	logic [31:0] ofs;
	logic [2:0]  tsel;
	logic [31:0] merged;
	logic        is_base;
	logic        is_attr;
	// ==========================================================
	// region hit test, one shared table for fetch and data
	genvar g;
	generate
		for (g = 0; g < mpu_pkg::NUM_REGIONS; g++) begin : g_rgn
			mpu_region_match u_match (
				.i_addr   (i_acc_addr),
				.i_base   (st_r.base[g]),
				.i_size   (st_r.attr[g][mpu_pkg::ATTR_SIZE_LO +: 5]),
				.i_srd    (st_r.attr[g][mpu_pkg::ATTR_SRD_LO +: 8]),
				.i_enable (st_r.attr[g][mpu_pkg::ATTR_ENABLE_BIT]),
				.o_hit    (hit[g])
			);
		end
	endgenerate
	// ==========================================================
	// priority: highest numbered hit wins
	always_comb begin
		win     = 3'h0;
		any_hit = 1'b0;
		for (int i = 0; i < mpu_pkg::NUM_REGIONS; i++) begin
			if (hit[i]) begin
				win     = 3'(i);
				any_hit = 1'b1;
			end
		end
		wattr = st_r.attr[win];
	end
	mpu_attr_decode u_dec (
		.i_tex   (wattr[mpu_pkg::ATTR_TEX_LO +: 3]),
		.i_s     (wattr[mpu_pkg::ATTR_S_BIT]),
		.i_c     (wattr[mpu_pkg::ATTR_C_BIT]),
		.i_b     (wattr[mpu_pkg::ATTR_B_BIT]),
		.i_ap    (wattr[mpu_pkg::ATTR_AP_LO +: 3]),
		.i_priv  (i_acc_priv),
		.i_write (i_acc_write),
		.o_type  (dtype),
		.o_share (dshare),
		.o_inner (dinner),
		.o_outer (douter),
		.o_allow (dallow)
	);
	// ==========================================================
	// register decode
	always_comb begin
		ofs     = i_reg_addr - mpu_pkg::ADDR_SELECT;
		is_base = 1'b0;
		is_attr = 1'b0;
		if (ofs[31:6] == 26'h0 && ofs[1:0] == 2'h0 && ofs != 32'h0 &&
		    ofs < 32'h24) begin
			// aliases repeat the base/attribute pair every eight bytes
			is_base = ofs[2];
			is_attr = !ofs[2];
		end
		tsel = st_r.sel;
		if (is_base && i_reg_wr &&
		    i_reg_wdata[mpu_pkg::BASE_VALID_BIT]) begin
			tsel = i_reg_wdata[mpu_pkg::BASE_REGION_LO +: 3];
		end
		merged = st_r.attr[st_r.sel];
		for (int b = 0; b < 4; b++) begin
			if (i_reg_be[b]) begin
				merged[b*8 +: 8] = i_reg_wdata[b*8 +: 8];
			end
		end
	end
	// ==========================================================
	// next state
	always_comb begin
		st_nxt       = st_r;
		st_nxt.rdata = mpu_pkg::RESET_VALUE;
		if (i_reg_wr) begin
			if (i_reg_addr == mpu_pkg::ADDR_SELECT) begin
				st_nxt.sel = i_reg_wdata[2:0];
			end else if (is_base) begin
				st_nxt.sel = tsel;
				st_nxt.base[tsel] = i_reg_wdata[31:mpu_pkg::BASE_ADDR_LO];
			end else if (is_attr) begin
				// byte strobes let halfword writes at +8 land in either half; +A is not decoded
				st_nxt.attr[st_r.sel] = merged;
			end
		end
		if (i_reg_rd) begin
			if (i_reg_addr == mpu_pkg::ADDR_SELECT) begin
				st_nxt.rdata = {29'h0, st_r.sel};
			end else if (is_base) begin
				st_nxt.rdata = {st_r.base[st_r.sel], 2'h0, st_r.sel};
			end else if (is_attr) begin
				st_nxt.rdata = st_r.attr[st_r.sel];
			end
		end
		// ======================================================
		// access check, one cycle after presentation
		st_nxt.fault = 1'b0;
		st_nxt.ok    = 1'b0;
		if (i_acc_valid) begin
			if (!i_mpu_enable) begin
				st_nxt.ok    = 1'b1;
				st_nxt.mtype = mpu_pkg::MT_NORMAL;
			end else if (any_hit) begin
				st_nxt.fault = !dallow ||
				    (i_acc_fetch && wattr[mpu_pkg::ATTR_XN_BIT]);
				st_nxt.ok    = dallow &&
				    !(i_acc_fetch && wattr[mpu_pkg::ATTR_XN_BIT]);
				st_nxt.mtype = dtype;
				st_nxt.share = dshare;
				st_nxt.inner = dinner;
				st_nxt.outer = douter;
			end else begin
				st_nxt.fault = !i_acc_priv;
				st_nxt.ok    = i_acc_priv;
				st_nxt.mtype = mpu_pkg::MT_NORMAL;
			end
		end
	end
	// ==========================================================
	// state register, regions 0..7 reset disabled
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r.sel   <= 3'h0;
			for (int r = 0; r < mpu_pkg::NUM_REGIONS; r++) begin
				st_r.base[r] <= 27'h0;
				st_r.attr[r] <= mpu_pkg::RESET_VALUE;
			end
			st_r.rdata <= mpu_pkg::RESET_VALUE;
			st_r.fault <= 1'b0;
			st_r.ok    <= 1'b0;
			st_r.mtype <= 2'h0;
			st_r.share <= 1'b0;
			st_r.inner <= 2'h0;
			st_r.outer <= 2'h0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_reg_rdata = st_r.rdata;
	assign o_fault     = st_r.fault;
	assign o_acc_ok    = st_r.ok;
	assign o_mem_type  = st_r.mtype;
	assign o_share     = st_r.share;
	assign o_inner     = st_r.inner;
	assign o_outer     = st_r.outer;
	// ==========================================================
	// checks
	logic       rgn_acc;
	logic [2:0] wap;
	logic [2:0] wtex;
	assign rgn_acc = i_acc_valid && i_mpu_enable && any_hit;
	assign wap     = wattr[mpu_pkg::ATTR_AP_LO +: 3];
	assign wtex    = wattr[mpu_pkg::ATTR_TEX_LO +: 3];
	AST_BG_USER_FAULT: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_acc_valid && i_mpu_enable && hit == 8'h00 && !i_acc_priv
		|=> o_fault && !o_acc_ok)
		else $error("unprivileged background access did not fault");
	AST_BG_PRIV_OK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_acc_valid && i_mpu_enable && !any_hit && i_acc_priv
		|=> o_acc_ok && o_mem_type == mpu_pkg::MT_NORMAL)
		else $error("privileged background access refused");
	AST_FAULT_XOR_OK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_acc_valid
		|=> (o_fault != o_acc_ok))
		else $error("access answer not exactly one of fault or ok");
	AST_NO_ACC_QUIET: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!i_acc_valid
		|=> !o_fault && !o_acc_ok)
		else $error("answer without an access");
	AST_OFF_PASS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_acc_valid && !i_mpu_enable
		|=> o_acc_ok && o_mem_type == mpu_pkg::MT_NORMAL)
		else $error("access refused with protection off");
	AST_SEL_WRITE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_reg_wr && i_reg_addr == mpu_pkg::ADDR_SELECT
		|=> st_r.sel == $past(i_reg_wdata[2:0]))
		else $error("select write not taken");
	AST_RD_IDLE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!i_reg_rd
		|=> o_reg_rdata == 32'h0)
		else $error("read data shown without a read");
	AST_UNALIGNED_IGNORED: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_reg_wr && i_reg_addr[1:0] != 2'h0
		|=> $stable(st_r.sel) && $stable(st_r.base) && $stable(st_r.attr))
		else $error("unaligned register write changed settings");
	AST_BASE_VALID_SEL: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_reg_wr && is_base && i_reg_wdata[mpu_pkg::BASE_VALID_BIT]
		|=> st_r.sel == $past(i_reg_wdata[2:0]))
		else $error("valid base write did not select region");
	AST_BASE_WRITE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_reg_wr && is_base
		|=> st_r.base[st_r.sel] == $past(i_reg_wdata[31:5]))
		else $error("base write did not land in selected region");
	AST_ATTR_WRITE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		i_reg_wr && is_attr && i_reg_be == 4'hF
		|=> st_r.attr[st_r.sel] == $past(i_reg_wdata))
		else $error("attribute word write did not land");
	AST_WIN_HIGHEST: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		any_hit
		|-> (hit >> win) == 8'h01)
		else $error("winning region is not the highest hit");
	AST_XN_FETCH: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && i_acc_fetch && wattr[mpu_pkg::ATTR_XN_BIT]
		|=> o_fault)
		else $error("fetch from execute-never region allowed");
	AST_FULL_OK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wap == mpu_pkg::AP_FULL &&
		!(i_acc_fetch && wattr[mpu_pkg::ATTR_XN_BIT])
		|=> o_acc_ok)
		else $error("full access region refused access");
	AST_AP_NONE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wap == mpu_pkg::AP_NONE
		|=> o_fault)
		else $error("no-access region allowed access");
	AST_AP_RSVD: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wap == mpu_pkg::AP_RSVD
		|=> o_fault)
		else $error("reserved permission allowed access");
	AST_AP_PRIV_ONLY: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wap == mpu_pkg::AP_PRIV_RW && !i_acc_priv
		|=> o_fault)
		else $error("privileged-only region allowed user access");
	AST_AP_USER_WR: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wap == mpu_pkg::AP_USER_RO && !i_acc_priv && i_acc_write
		|=> o_fault)
		else $error("user write to user read-only region allowed");
	AST_RO_WRITE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wap >= mpu_pkg::AP_PRIV_RO && i_acc_write
		|=> o_fault)
		else $error("write to read-only region allowed");
	AST_TYPE_STRONG: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wtex == 3'h0 && !wattr[17] && !wattr[16]
		|=> o_mem_type == mpu_pkg::MT_STRONG && o_share)
		else $error("strongly ordered code decoded wrongly");
	AST_TYPE_DEVICE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wtex == 3'h0 && !wattr[17] && wattr[16]
		|=> o_mem_type == mpu_pkg::MT_DEVICE && o_share)
		else $error("device code decoded wrongly");
	AST_TYPE_NC: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wtex == 3'h1 && !wattr[17] && !wattr[16]
		|=> o_mem_type == mpu_pkg::MT_NORMAL && o_inner == 2'h0)
		else $error("non-cacheable normal code decoded wrongly");
	AST_TYPE_RSVD: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wtex == 3'h3
		|=> o_mem_type == mpu_pkg::MT_RSVD)
		else $error("reserved type code not flagged");
	AST_TYPE_CACHED: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		rgn_acc && wtex[2]
		|=> o_mem_type == mpu_pkg::MT_NORMAL &&
		o_outer == $past(wtex[1:0]) && o_inner == $past(wattr[17:16]))
		else $error("cached normal policy decoded wrongly");
endmodule
`default_nettype wire

// ==== rtl/mpu_pkg.sv ====
// mpu_pkg: register map, field layout and attribute codes of the region checker
// assumes: one processor clock domain, byte-addressed register bus with word registers
package mpu_pkg;
	// ==========================================================
	// register map
	localparam logic [31:0] ADDR_SELECT     = 32'hE000ED98;
	localparam logic [31:0] OFS_BASE        = 32'h00000004;
	localparam logic [31:0] OFS_ATTR        = 32'h00000008;
	localparam logic [31:0] OFS_ALIAS_STEP  = 32'h00000008;
	localparam int          NUM_ALIAS       = 4;
	localparam int          NUM_REGIONS     = 8;
	localparam logic [31:0] RESET_VALUE     = 32'h00000000;
	// ==========================================================
	// base register fields
	localparam int BASE_VALID_BIT = 4;
	localparam int BASE_REGION_LO = 0;
	localparam int BASE_ADDR_LO   = 5;
	// ==========================================================
	// attribute and size word fields
	localparam int ATTR_ENABLE_BIT = 0;
	localparam int ATTR_SIZE_LO    = 1;
	localparam int ATTR_SRD_LO     = 8;
	localparam int ATTR_B_BIT      = 16;
	localparam int ATTR_C_BIT      = 17;
	localparam int ATTR_S_BIT      = 18;
	localparam int ATTR_TEX_LO     = 19;
	localparam int ATTR_AP_LO      = 24;
	localparam int ATTR_XN_BIT     = 28;
	localparam logic [4:0] SIZE_MIN_SUB = 5'h07;
	// ==========================================================
	// access permission codes
	localparam logic [2:0] AP_NONE    = 3'h0;
	localparam logic [2:0] AP_PRIV_RW = 3'h1;
	localparam logic [2:0] AP_USER_RO = 3'h2;
	localparam logic [2:0] AP_FULL    = 3'h3;
	localparam logic [2:0] AP_RSVD    = 3'h4;
	localparam logic [2:0] AP_PRIV_RO = 3'h5;
	// ==========================================================
	// memory types
	typedef enum logic [1:0] {
		MT_STRONG = 2'b00,
		MT_DEVICE = 2'b01,
		MT_NORMAL = 2'b10,
		MT_RSVD   = 2'b11
	} mem_type_t;
	// cache policy codes
	localparam logic [1:0] CP_NONCACHE = 2'h0;
	localparam logic [1:0] CP_WB_WRA   = 2'h1;
	localparam logic [1:0] CP_WT_NOWA  = 2'h2;
	localparam logic [1:0] CP_WB_NOWA  = 2'h3;
endpackage

// ==== rtl/mpu_region_match.sv ====
// mpu_region_match: address hit test of one region with subregion disable
// assumes: settings stable, address presented combinationally
`timescale 1ns/100ps
`default_nettype none
module mpu_region_match (
	input  wire logic [31:0] i_addr,
	input  wire logic [26:0] i_base,
	input  wire logic [4:0]  i_size,
	input  wire logic [7:0]  i_srd,
	input  wire logic        i_enable,
	output logic             o_hit
);
	logic [31:0] mask;
	logic [2:0]  sub;
	logic        in_rgn;
	// ==========================================================
	// region window
	always_comb begin
		mask   = (32'h2 << i_size) - 32'h1;
		in_rgn = ((i_addr & ~mask) == ({i_base, 5'h00} & ~mask));
		sub    = 3'h0;
		if (i_size >= mpu_pkg::SIZE_MIN_SUB) begin
			sub = 3'((i_addr >> (i_size - 5'h2)) & 32'h7);
		end
		// disabled subregion leaves the address to lower regions
		o_hit = i_enable && i_size >= 5'h4 && in_rgn && !i_srd[sub];
	end
endmodule
`default_nettype wire

// ==== rtl/mpu_attr_decode.sv ====
// mpu_attr_decode: memory type and permission decode of one region setting
// assumes: attribute fields taken from the winning region
`timescale 1ns/100ps
`default_nettype none
module mpu_attr_decode (
	input  wire logic [2:0]          i_tex,
	input  wire logic                i_s,
	input  wire logic                i_c,
	input  wire logic                i_b,
	input  wire logic [2:0]          i_ap,
	input  wire logic                i_priv,
	input  wire logic                i_write,
	output mpu_pkg::mem_type_t       o_type,
	output logic                     o_share,
	output logic [1:0]               o_inner,
	output logic [1:0]               o_outer,
	output logic                     o_allow
);
	// ==========================================================
	// memory type
	always_comb begin
		o_type  = mpu_pkg::MT_RSVD;
		o_share = i_s;
		o_inner = mpu_pkg::CP_NONCACHE;
		o_outer = mpu_pkg::CP_NONCACHE;
		if (i_tex[2]) begin
			o_type  = mpu_pkg::MT_NORMAL;
			o_inner = {i_c, i_b};
			o_outer = i_tex[1:0];
		end else if (i_tex == 3'h0) begin
			if (!i_c && !i_b) begin
				o_type  = mpu_pkg::MT_STRONG;
				o_share = 1'b1;
			end else if (!i_c) begin
				o_type  = mpu_pkg::MT_DEVICE;
				o_share = 1'b1;
			end else begin
				o_type  = mpu_pkg::MT_NORMAL;
				o_inner = mpu_pkg::CP_WT_NOWA;
				o_outer = mpu_pkg::CP_WT_NOWA;
			end
		end else if (i_tex == 3'h1) begin
			if (!i_c && !i_b) begin
				o_type = mpu_pkg::MT_NORMAL;
			end else if (i_c && i_b) begin
				o_type  = mpu_pkg::MT_NORMAL;
				o_inner = mpu_pkg::CP_WB_WRA;
				o_outer = mpu_pkg::CP_WB_WRA;
			end
		end else if (i_tex == 3'h2 && !i_c && !i_b) begin
			o_type  = mpu_pkg::MT_DEVICE;
			o_share = 1'b0;
		end
	end
	// ==========================================================
	// access permission
	always_comb begin
		case (i_ap)
			mpu_pkg::AP_NONE:    o_allow = 1'b0;
			mpu_pkg::AP_PRIV_RW: o_allow = i_priv;
			mpu_pkg::AP_USER_RO: o_allow = i_priv || !i_write;
			mpu_pkg::AP_FULL:    o_allow = 1'b1;
			mpu_pkg::AP_RSVD:    o_allow = 1'b0;
			mpu_pkg::AP_PRIV_RO: o_allow = i_priv && !i_write;
			default:             o_allow = !i_write;
		endcase
	end
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
// core_model: processor side issuing checked accesses
// assumes: shared clock, requests launched off the falling edge
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input  wire logic   i_clk,
	output logic        o_valid,
	output logic [31:0] o_addr,
	output logic        o_priv,
	output logic        o_write,
	output logic        o_fetch
);
	initial begin
		o_valid = 1'h0;
		{o_addr, o_priv, o_write, o_fetch} = 35'h0;
	end
	// ==========================================================
	// one access per call, qualifiers travel with it
	task automatic issue(input logic [31:0] a, input logic p, w, f);
		@(negedge i_clk);
		o_valid = 1'h1;
		{o_addr, o_priv, o_write, o_fetch} = {a, p, w, f};
		rest();
	endtask
	// released lines show inverted leftovers
	task automatic rest();
		@(negedge i_clk);
		o_valid = 1'h0;
		{o_addr, o_priv, o_write, o_fetch} =
			~{o_addr, o_priv, o_write, o_fetch};
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// tb: register programming and access checks of the region checker
// assumes: core_model drives the access side
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {
		logic chk_ok; logic ok; logic [1:0] typ;
		logic chk_c; logic sh; logic [1:0] inn; logic [1:0] outr;
	} note_t;
	logic        clk, nrst, reg_wr, reg_rd, mpu_en, rd_pend, acc_pend;
	logic [31:0] reg_addr, wdata, rdata, a_addr, rnd;
	logic [3:0]  be;
	logic        a_valid, a_priv, a_write, a_fetch, fault, acc_ok, share;
	logic [1:0]  mtype, inner, outer;
	note_t       cur;
	note_t       exp_n;
	note_t       acc_q[$];
	logic [31:0] rd_q[$];
	int          error_cnt, n_compared;
	localparam logic [31:0] SEL = mpu_pkg::ADDR_SELECT;
	mpu_region_checker mpu_region_checker_i (.i_clk(clk), .i_nrst(nrst),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
		.i_reg_be(be), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_mpu_enable(mpu_en), .i_acc_valid(a_valid), .i_acc_addr(a_addr),
		.i_acc_priv(a_priv), .i_acc_write(a_write), .i_acc_fetch(a_fetch),
		.o_fault(fault), .o_acc_ok(acc_ok), .o_mem_type(mtype),
		.o_share(share), .o_inner(inner), .o_outer(outer));
	core_model core_model_i (.i_clk(clk), .o_valid(a_valid),
		.o_addr(a_addr), .o_priv(a_priv), .o_write(a_write),
		.o_fetch(a_fetch));
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] attr(input logic xn, input logic [2:0] ap,
		input logic [2:0] t, input logic s, c, b, input logic [7:0] subregion_disable_mask,
		input logic [4:0] sz, input logic en);
		return {3'h0, xn, 1'h0, ap, 2'h0, t, s, c, b, subregion_disable_mask, 2'h0, sz, en};
	endfunction
	function automatic logic perm_ok(input logic [2:0] ap, input logic p, w);
		case (ap)
			3'h1: return p;
			3'h2: return p | !w;
			3'h3: return 1'h1;
			3'h5: return p & !w;
			3'h6, 3'h7: return !w;
			default: return 1'h0;
		endcase
	endfunction
	function automatic logic [1:0] typ_of(input logic [2:0] t,
		input logic [1:0] cb);
		if (t[2])
			return 2'h2;
		case ({t[1:0], cb})
			4'h0: return 2'h0;
			4'h1, 4'h8: return 2'h1;
			4'h2, 4'h3, 4'h4, 4'h7: return 2'h2;
			default: return 2'h3;
		endcase
	endfunction
	function automatic note_t ex(input logic ok);
		return {1'h1, ok, 2'h2, 6'h0};
	endfunction
	task automatic cmp(input string what, input logic [31:0] e, s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, e, s);
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [3:0] b);
		@(negedge clk);
		{reg_wr, reg_rd, reg_addr, wdata, be} = {1'h1, 1'h0, a, d, b};
	endtask
	task automatic rd(input logic [31:0] a, e);
		@(negedge clk);
		{reg_wr, reg_rd, reg_addr, be} = {1'h0, 1'h1, a, 4'hF};
		rd_q.push_back(e);
	endtask
	task automatic idle();
		@(negedge clk);
		{reg_wr, reg_rd} = 2'h0;
	endtask
	task automatic chk(input logic [31:0] a, input logic p, w, f,
		input note_t n);
		acc_q.push_back(n);
		core_model_i.issue(a, p, w, f);
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// clock, watchdog, result monitor
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#75000;
		error_cnt++;
		close_out();
	end
	always @(posedge clk) begin
		rd_pend <= reg_rd;
		acc_pend <= a_valid;
	end
	always @(negedge clk) begin
		if (rd_pend === 1'h1 && rd_q.size() > 0)
			cmp("rdata", rd_q.pop_front(), rdata);
		if (acc_pend === 1'h1 && acc_q.size() > 0) begin
			cur = acc_q.pop_front();
			cmp("one_answer", 32'h1, {31'h0, fault ^ acc_ok});
			if (cur.chk_ok)
				cmp("acc_ok", {31'h0, cur.ok}, {31'h0, acc_ok});
			if (!cur.chk_ok || cur.ok)
				cmp("mem_type", {30'h0, cur.typ}, {30'h0, mtype});
			if (cur.chk_c)
				cmp("attr", {27'h0, cur.sh, cur.inn, cur.outr},
					{27'h0, share, inner, outer});
		end
	end
	// ==========================================================
	// tests
	initial begin
		{nrst, reg_wr, reg_rd, mpu_en, be} = 8'h0;
		{reg_addr, wdata} = 64'h0;
		{error_cnt, n_compared} = 64'h0;
		rnd = 32'h0EA26D69;
		repeat (6) @(posedge clk);
		@(negedge clk) nrst = 1'h1;
		rd(SEL, 32'h0);
		rd(SEL + 32'h8, 32'h0);
		rd(32'hE000EDC0, 32'h0);
		wr(SEL, 32'h3, 4'hF);
		wr(SEL + 32'h1, 32'h6, 4'hF);
		rd(SEL, 32'h3);
		idle();
		$display("test registers done");
		chk(32'h10000000, 1'h0, 1'h1, 1'h0, ex(1'h1));
		@(negedge clk) mpu_en = 1'h1;
		chk(32'h10000000, 1'h1, 1'h0, 1'h0, ex(1'h1));
		chk(32'h10000000, 1'h0, 1'h0, 1'h0, ex(1'h0));
		$display("test background done");
		wr(SEL, 32'h2, 4'hF);
		wr(SEL + 32'h4, 32'h20000000, 4'hF);
		wr(SEL + 32'h8, attr(0, 3, 0, 1, 1, 0, 0, 9, 1), 4'hF);
		rd(SEL + 32'h4, 32'h20000002);
		rd(SEL + 32'h8, attr(0, 3, 0, 1, 1, 0, 0, 9, 1));
		idle();
		chk(32'h200003FF, 1'h0, 1'h1, 1'h0, ex(1'h1));
		chk(32'h20000400, 1'h0, 1'h0, 1'h0, ex(1'h0));
		$display("test region program done");
		wr(SEL + 32'hC, 32'h20000015, 4'hF);
		wr(SEL + 32'h10, attr(0, 2, 0, 0, 1, 0, 0, 7, 1), 4'hF);
		rd(SEL, 32'h5);
		idle();
		chk(32'h20000010, 1'h0, 1'h1, 1'h0, ex(1'h0));
		chk(32'h20000010, 1'h0, 1'h0, 1'h0, ex(1'h1));
		chk(32'h20000100, 1'h0, 1'h1, 1'h0, ex(1'h1));
		$display("test overlap done");
		wr(SEL + 32'h8, 32'h00000100, 4'h2);
		idle();
		chk(32'h20000010, 1'h0, 1'h1, 1'h0, ex(1'h1));
		chk(32'h20000020, 1'h0, 1'h1, 1'h0, ex(1'h0));
		wr(SEL, 32'h2, 4'hF);
		wr(SEL + 32'h8, 32'h00000012, 4'h3);
		idle();
		chk(32'h20000010, 1'h0, 1'h1, 1'h0, ex(1'h0));
		chk(32'h20000010, 1'h1, 1'h1, 1'h0, ex(1'h1));
		$display("test subregions done");
		wr(SEL + 32'h4, 32'h40000017, 4'hF);
		for (int ap = 0; ap < 8; ap++) begin
			wr(SEL + 32'h8, attr(0, ap, 0, 0, 1, 0, 0, 7, 1), 4'hF);
			idle();
			for (int i = 0; i < 4; i++) begin
				rnd = lfsr(rnd);
				chk({24'h400000, rnd[7:2], 2'h0}, i[1], i[0],
					rnd[8] & !i[0], ex(perm_ok(ap, i[1], i[0])));
			end
		end
		wr(SEL + 32'h8, attr(1, 3, 0, 0, 1, 0, 0, 7, 1), 4'hF);
		idle();
		chk(32'h40000040, 1'h1, 1'h0, 1'h1, ex(1'h0));
		chk(32'h40000040, 1'h1, 1'h0, 1'h0, ex(1'h1));
		$display("test permissions done");
		for (int t = 0; t < 8; t++) begin
			for (int cb = 0; cb < 4; cb++) begin
				if (t != 3) begin
					rnd = lfsr(rnd);
					wr(SEL + 32'h8, attr(0, 3, t, rnd[0], cb[1], cb[0], 0, 7, 1),
						4'hF);
					idle();
					exp_n = {typ_of(t, cb) != 2'h3, 1'h1, typ_of(t, cb), t[2],
						rnd[0], cb[1:0], t[1:0]};
					chk(32'h40000040, 1'h1, 1'h0, 1'h0, exp_n);
				end
			end
		end
		$display("test memory types done");
		wr(SEL + 32'h1C, 32'h20000015, 4'hF);
		wr(SEL + 32'h20, 32'h0, 4'hF);
		wr(SEL + 32'h4, 32'h30000013, 4'hF);
		wr(SEL + 32'h8, attr(0, 3, 0, 1, 1, 0, 0, 4, 1), 4'hF);
		idle();
		chk(32'h20000020, 1'h0, 1'h0, 1'h0, ex(1'h0));
		chk(32'h3000001C, 1'h0, 1'h1, 1'h0, ex(1'h1));
		chk(32'h30000020, 1'h0, 1'h0, 1'h0, ex(1'h0));
		$display("test small region done");
		repeat (4) @(negedge clk);
		close_out();
	end
endmodule
`default_nettype wire
